// >>> dv/ers_host_model.sv
// host reading the status register
`timescale 1ns/1ps
`default_nettype none
module ers_host_model (
    input  wire logic        mclk_i,
    input  wire logic        rvalid_i,
    input  wire logic [23:0] rdata_i,
    output logic             rd_en_o = 1'b0,
    output logic [5:0]       addr_o = 6'h00
);
    // thresholds taken as set
    // address shows its inverse once released
    task automatic read(input logic [5:0] a, output logic [23:0] d, output logic v);
        @(posedge mclk_i);
        #1;
        rd_en_o = 1'b1;
        addr_o = a;
        @(posedge mclk_i);
        #1;
        rd_en_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule // ers_host_model
`default_nettype wire

// >>> dv/ers_status_flags_properties.sv
// port assertions of the status flag block
`timescale 1ns/1ps
`default_nettype none
module ers_props (
    input wire logic               mclk_i,
    input wire logic               srst_i,
    input wire logic               conv_valid_i,
    input wire logic [4:0]         chan_oor_i,
    input wire ers_pkg::ers_mode_t lead_mode_i,
    input wire logic               frame_load_i,
    input wire logic               rd_en_i,
    input wire logic [5:0]         addr_i,
    input wire logic [23:0]        rdata_o,
    input wire logic               rvalid_o,
    input wire logic [23:0]        frame_status_o,
    input wire ers_pkg::ers_mode_t frame_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // channel one lands on the highest flag bit
    wire logic [4:0] hit_w = {chan_oor_i[0], chan_oor_i[1], chan_oor_i[2], chan_oor_i[3], chan_oor_i[4]};
    a_read_answer: assert property (rd_en_i |=> rvalid_o) else $error("no read answer");
    a_valid_only_read: assert property (!rd_en_i |=> !rvalid_o) else $error("stray valid");
    a_unmapped_zero: assert property (rd_en_i && addr_i != 6'h1D |=> rdata_o == 24'h00_0000)
        else $error("unmapped read not zero");
    a_rsvd_zero: assert property (rvalid_o |-> (rdata_o & 24'h03_C07B) == 24'h00_0000)
        else $error("reserved read bit set");
    a_frame_rsvd: assert property ((frame_status_o & 24'hFF_E0FF) == 24'h00_0000)
        else $error("reserved frame bit set");
    a_frame_hit: assert property (frame_load_i && conv_valid_i |=>
        (frame_status_o[12:8] & $past(hit_w)) == $past(hit_w)) else $error("hit lost at load");
    a_frame_hold: assert property (!frame_load_i |=> $stable(frame_status_o)) else $error("frame moved");
    a_mode_capture: assert property (frame_load_i |=> frame_mode_o == $past(lead_mode_i))
        else $error("mode not captured");
    a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o)) else $error("read data moved");
endmodule // ers_props
bind ers_status_flags ers_props u_props (.mclk_i, .srst_i, .conv_valid_i, .chan_oor_i, .lead_mode_i,
    .frame_load_i, .rd_en_i, .addr_i, .rdata_o, .rvalid_o, .frame_status_o, .frame_mode_o);
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench of the status flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t value mismatch %h %h", $time, a, e); end end
module tb_top;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    ers_pkg::ers_elec_t ov = '0, un = '0;
    ers_pkg::ers_mode_t md = ers_pkg::ERS_MODE_ELECTRODE, fm;
    logic cv = 1'b0, fl = 1'b0, wr = 1'b0, rd, rv, v;
    logic [4:0] oor = 5'h00, acc;
    logic [5:0] ad;
    logic [23:0] wd = 24'h00_0000, rdat, fs, d;
    logic [15:0] rnd = 16'h0022;
    int error_cnt = 0;
    int checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    ers_status_flags dut (.mclk_i, .srst_i, .over_cmp_i(ov), .under_cmp_i(un), .conv_valid_i(cv),
        .chan_oor_i(oor), .lead_mode_i(md), .frame_load_i(fl), .rd_en_i(rd), .wr_en_i(wr), .addr_i(ad),
        .wdata_i(wd), .rdata_o(rdat), .rvalid_o(rv), .frame_status_o(fs), .frame_mode_o(fm));
    ers_host_model host (.mclk_i, .rvalid_i(rv), .rdata_i(rdat), .rd_en_o(rd), .addr_o(ad));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [23:0] elec(input ers_pkg::ers_elec_t o, input ers_pkg::ers_elec_t u);
        return {o.drive, o.limb, 4'h0, o.common, u.drive, u.limb, 4'h0, u.common, 2'h0};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        #1;
        srst_i = 1'b0;
        host.read(6'h1D, d, v);
        `CHK(d, 24'h00_0000)
        `CHK(v, 1'b1)
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            {ov, un} = (i == 0) ? 14'h3FFF : rnd[13:0];
            wr = 1'b1;
            wd = {rnd, rnd[7:0]};
            repeat (6) @(posedge mclk_i);
            host.read(6'h1D, d, v);
            `CHK(d, elec(ov, un))
            `CHK(v, 1'b1)
            host.read({1'b1, rnd[4:0]}, d, v);
            `CHK(d, 24'h00_0000)
        end
        $display("electrode test done");
        for (int f = 0; f < 12; f++) begin
            acc = 5'h00;
            for (int k = 0; k < 4; k++) begin
                @(posedge mclk_i);
                #1;
                rnd = lfsr(rnd);
                cv = rnd[5] && f != 1;
                oor = rnd[4:0];
                fl = k == 3;
                if (cv) acc = acc | oor;
            end
            @(posedge mclk_i);
            #1;
            cv = 1'b0;
            fl = 1'b0;
            `CHK(fs, {11'h000, acc[0], acc[1], acc[2], acc[3], acc[4], 8'h00})
            `CHK(fm, md)
            md = (rnd[7:6] == 2'h2) ? ers_pkg::ERS_MODE_ELECTRODE : ers_pkg::ers_mode_t'(rnd[7:6]);
        end
        $display("frame test done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire

// >>> logic/ers_defines.svh
// offsets, field positions and reset values of the electrode range status flags
`ifndef ERS_DEFINES_SVH
`define ERS_DEFINES_SVH

`define ERS_ADDR_W              6
`define ERS_DATA_W              24
`define ERS_ELECTRODE_RANGE_ADR 6'h1D
`define ERS_ELECTRODE_RST       24'h00_0000
`define ERS_FRAME_STATUS_RST    24'h00_0000
`define ERS_NUM_CHAN            5
`define ERS_CHAN_OOR_MSB        12
`define ERS_CHAN_OOR_LSB        8
`define ERS_OVER_DRIVE_BIT      23
`define ERS_OVER_LIMB_MSB       22
`define ERS_OVER_LIMB_LSB       18
`define ERS_OVER_COMMON_BIT     13
`define ERS_UNDER_DRIVE_BIT     12
`define ERS_UNDER_LIMB_MSB      11
`define ERS_UNDER_LIMB_LSB      7
`define ERS_UNDER_COMMON_BIT    2
`define ERS_NUM_LIMB            5

`endif

// >>> logic/ers_pkg.sv
// types of the electrode range status flags
`default_nettype none
package ers_pkg;
    // comparator levels of the drive, five limb and common electrodes
    typedef struct packed {
        logic       drive;
        logic [4:0] limb;
        logic       common;
    } ers_elec_t;

    typedef enum logic [1:0] {
        ERS_MODE_ELECTRODE = 2'h0,
        ERS_MODE_ANALOG_LEAD = 2'h1,
        ERS_MODE_DIGITAL_LEAD = 2'h3
    } ers_mode_t;

    typedef struct packed {
        logic [4:0] over;
        logic [4:0] under;
    } ers_chan_cmp_t;
endpackage
`default_nettype wire

// >>> logic/ers_status_flags.sv
// electrode range and per-channel out-of-range status flags
//
// Notes on behaviour
// - channels two to five flag bits 11..8
// - channel one flag sits at bit 12
// - flags sticky per frame, cleared on transfer
// - flags name electrode or lead per mode
// - electrode range register 0x1D, read-only, zero reset
// - over-range bits 23, 22..18, 13 above 2.4V
// - under-range bits 12, 11..7, 2 below 0.2V
// - each bit follows own fixed comparator
`timescale 1ns/1ps
`default_nettype none
`include "ers_defines.svh"
module ers_status_flags (
    input  wire logic                         mclk_i,
    input  wire logic                         srst_i,
    // comparator outputs from the analog side
    input  wire ers_pkg::ers_elec_t           over_cmp_i,
    input  wire ers_pkg::ers_elec_t           under_cmp_i,
    // per-channel range results from the conversion path
    input  wire logic                         conv_valid_i,
    input  wire logic [`ERS_NUM_CHAN-1:0]     chan_oor_i,
    input  wire ers_pkg::ers_mode_t           lead_mode_i,
    input  wire logic                         frame_load_i,
    // register read and write port of the serial interface
    input  wire logic                         rd_en_i,
    input  wire logic                         wr_en_i,
    input  wire logic [`ERS_ADDR_W-1:0]       addr_i,
    input  wire logic [`ERS_DATA_W-1:0]       wdata_i,
    output logic      [`ERS_DATA_W-1:0]       rdata_o,
    output logic                              rvalid_o,
    // status word handed to the serial output buffer
    output logic      [`ERS_DATA_W-1:0]       frame_status_o,
    output var ers_pkg::ers_mode_t            frame_mode_o
);
    // ------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------
    ers_pkg::ers_elec_t over_lvl, under_lvl;
    // a pin change reaches the register five clocks later

    ers_sync3 #(.W(7)) u_sync_over (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .async_i (over_cmp_i),
        .level_o (over_lvl)
    );

    ers_sync3 #(.W(7)) u_sync_under (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .async_i (under_cmp_i),
        .level_o (under_lvl)
    );

    // ------------------------------------------------------------
    // electrode range status register
    // ------------------------------------------------------------
    function automatic logic [`ERS_DATA_W-1:0] pack_elec(
        input ers_pkg::ers_elec_t ov,
        input ers_pkg::ers_elec_t un
    );
        logic [`ERS_DATA_W-1:0] w;
        w = `ERS_ELECTRODE_RST;
        w[`ERS_OVER_DRIVE_BIT]                      = ov.drive;
        w[`ERS_OVER_LIMB_MSB:`ERS_OVER_LIMB_LSB]    = ov.limb;
        w[`ERS_OVER_COMMON_BIT]                     = ov.common;
        w[`ERS_UNDER_DRIVE_BIT]                     = un.drive;
        w[`ERS_UNDER_LIMB_MSB:`ERS_UNDER_LIMB_LSB]  = un.limb;
        w[`ERS_UNDER_COMMON_BIT]                    = un.common;
        return w;
    endfunction

    logic [`ERS_DATA_W-1:0] elec_reg, elec_next;

    always_comb begin
        elec_next = pack_elec(over_lvl, under_lvl);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            elec_reg <= `ERS_ELECTRODE_RST;
        end else begin
            elec_reg <= elec_next;
        end
    end

    // ------------------------------------------------------------
    // per-channel out-of-range accumulation
    // ------------------------------------------------------------
    logic [`ERS_NUM_CHAN-1:0] acc_reg, acc_next;
    logic [`ERS_NUM_CHAN-1:0] hit;

    always_comb begin
        // channel index means electrode or lead by mode
        hit      = conv_valid_i ? chan_oor_i : '0;
        acc_next = acc_reg | hit;
        if (frame_load_i) begin
            acc_next = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // ------------------------------------------------------------
    // frame copy handed to the serial output buffer
    // ------------------------------------------------------------
    logic [`ERS_NUM_CHAN-1:0] frm_reg, frm_next;

    always_comb begin
        frm_next = frm_reg;
        if (frame_load_i) begin
            frm_next = acc_reg | hit;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            frm_reg <= '0;
        end else begin
            frm_reg <= frm_next;
        end
    end

    // ------------------------------------------------------------
    // lead mode captured with the frame
    // ------------------------------------------------------------
    ers_pkg::ers_mode_t mode_reg, mode_next;

    always_comb begin
        mode_next = mode_reg;
        if (frame_load_i) begin
            mode_next = lead_mode_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mode_reg <= ers_pkg::ERS_MODE_ELECTRODE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // frame status word
    // ------------------------------------------------------------
    // chan_oor_i[0] is channel one
    function automatic logic [`ERS_DATA_W-1:0] pack_chan(input logic [`ERS_NUM_CHAN-1:0] f);
        logic [`ERS_DATA_W-1:0] w;
        w = `ERS_FRAME_STATUS_RST;
        w[`ERS_CHAN_OOR_MSB] = f[0];
        for (int i = 1; i < `ERS_NUM_CHAN; i++) begin
            w[`ERS_CHAN_OOR_MSB - i] = f[i];
        end
        return w;
    endfunction

    assign frame_status_o = pack_chan(frm_reg);
    assign frame_mode_o   = mode_reg;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // unmapped addresses read zero
    function automatic logic [`ERS_DATA_W-1:0] read_word(
        input logic [`ERS_ADDR_W-1:0] a,
        input logic [`ERS_DATA_W-1:0] e
    );
        logic [`ERS_DATA_W-1:0] w;
        w = `ERS_ELECTRODE_RST;
        if (a == `ERS_ELECTRODE_RANGE_ADR) begin
            w = e;
        end
        return w;
    endfunction

    logic [`ERS_DATA_W-1:0] rdata_reg, rdata_next;
    logic                   rvalid_reg, rvalid_next;

    always_comb begin
        rvalid_next = rd_en_i;
        rdata_next  = rdata_reg;
        if (rd_en_i) begin
            rdata_next = read_word(addr_i, elec_reg);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_reg  <= `ERS_ELECTRODE_RST;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // write port
    // ------------------------------------------------------------
    // writes have no effect
    logic unused_wr;
    assign unused_wr = wr_en_i ^ (^wdata_i);

    assign rdata_o  = rdata_reg;
    assign rvalid_o = rvalid_reg;
endmodule // ers_status_flags
`default_nettype wire

// >>> logic/ers_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ers_sync3 #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [W-1:0] s1_next, s2_next, s3_next, lvl_next;

    always_comb begin
        s1_next  = async_i;
        s2_next  = s1_reg;
        s3_next  = s2_reg;
        lvl_next = lvl_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    assign level_o = lvl_reg;
endmodule // ers_sync3
`default_nettype wire
